/* design/ptwu_timer_watchdog.sv */
`timescale 1ns/10ps
`include "ptwu_map.svh"

module ptwu_timer_watchdog #(
  parameter int WIDTH = 16,
  parameter int TB_DIVIDE = `PTWU_TB_DIVIDE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire ptwu_pkg::ptwu_word_type reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output ptwu_pkg::ptwu_word_type reg_rdata,
  // Tick input
  input wire logic timer_tick_clock,
  // System bus monitor
  input wire logic data_strobe_n,
  input wire logic transfer_ready_n,
  input wire logic transfer_is_io,
  input wire logic timeout_disable_n,
  output logic strobe_suppress,
  output logic bus_cycle_abort,
  output logic instr_abort,
  // Watchdog and status
  output logic watchdog_expired_n,
  output ptwu_pkg::ptwu_word_type fault_flags,
  output ptwu_pkg::ptwu_word_type pending_irq,
  output logic extended_mode,
  output logic console_mode
);
  import ptwu_pkg::*;

  localparam logic [WIDTH-1:0] MAXV = '1;
  localparam logic [3:0] DIV_LAST = 4'(TB_DIVIDE - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_ctrl;
  logic wr_wd_rel;
  logic go_cmd;
  logic wr_cmd;
  logic wr_fault;
  logic wr_mask;
  logic wr_pend;
  logic [1:0] load_cmd;
  logic [1:0] reload_write_cmd;
  logic [1:0] start_cmd;
  logic [1:0] halt_cmd;

  always_comb
  begin
    wr_ctrl = reg_write && reg_addr == `PTWU_CTRL_OFF;
    wr_wd_rel = reg_write && reg_addr == `PTWU_WD_RELOAD_OFF;
    go_cmd = reg_write && reg_addr == `PTWU_WD_COUNT_OFF;
    wr_cmd = reg_write && reg_addr == `PTWU_TIMER_CMD_OFF;
    wr_fault = reg_write && reg_addr == `PTWU_FAULT_OFF;
    wr_mask = reg_write && reg_addr == `PTWU_FAULT_MASK_OFF;
    wr_pend = reg_write && reg_addr == `PTWU_PENDING_OFF;
    load_cmd[0] = reg_write && reg_addr == `PTWU_TA_COUNT_OFF;
    load_cmd[1] = reg_write && reg_addr == `PTWU_TB_COUNT_OFF;
    reload_write_cmd[0] = reg_write && reg_addr == `PTWU_TA_RELOAD_OFF;
    reload_write_cmd[1] = reg_write && reg_addr == `PTWU_TB_RELOAD_OFF;
    start_cmd[0] = wr_cmd && reg_wdata[`PTWU_CMD_A_START_BIT];
    halt_cmd[0] = wr_cmd && reg_wdata[`PTWU_CMD_A_HALT_BIT];
    start_cmd[1] = wr_cmd && reg_wdata[`PTWU_CMD_B_START_BIT];
    halt_cmd[1] = wr_cmd && reg_wdata[`PTWU_CMD_B_HALT_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  logic tick_q;
  logic dsn_q;
  logic tick_fall;
  logic strobe_fall;

  always_comb
  begin
    tick_fall = tick_q && !timer_tick_clock;
    strobe_fall = dsn_q && !data_strobe_n;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tick_q <= 1'b0;
      dsn_q <= 1'b1;
    end
    else
    begin
      tick_q <= timer_tick_clock;
      dsn_q <= data_strobe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic ext_q;
  logic ext_d;
  logic con_q;
  logic con_d;

  always_comb
  begin
    ext_d = ext_q;
    con_d = con_q;
    if (wr_ctrl)
    begin
      ext_d = reg_wdata[`PTWU_CTRL_EXT_BIT];
      con_d = reg_wdata[`PTWU_CTRL_CONSOLE_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ext_q <= 1'b0;
      con_q <= 1'b0;
    end
    else
    begin
      ext_q <= ext_d;
      con_q <= con_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog

  logic [WIDTH-1:0] wd_cnt_q;
  logic [WIDTH-1:0] wd_cnt_d;
  logic [WIDTH-1:0] wd_rel_q;
  logic [WIDTH-1:0] wd_rel_d;
  logic wd_exp_n_q;
  logic wd_exp_n_d;

  always_comb
  begin
    wd_cnt_d = wd_cnt_q;
    wd_exp_n_d = wd_exp_n_q;
    wd_rel_d = wd_rel_q;
    if (wr_wd_rel)
      wd_rel_d = reg_wdata[WIDTH-1:0];
    if (tick_fall)
    begin
      wd_cnt_d = wd_cnt_q + 1'b1;
      if (wd_cnt_q == MAXV)
        wd_exp_n_d = 1'b0;
    end
    if (go_cmd)
    begin
      wd_cnt_d = wd_rel_q;
      wd_exp_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wd_cnt_q <= '0;
      wd_rel_q <= `PTWU_WD_RELOAD_RST;
      wd_exp_n_q <= 1'b1;
    end
    else
    begin
      wd_cnt_q <= wd_cnt_d;
      wd_rel_q <= wd_rel_d;
      wd_exp_n_q <= wd_exp_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval timers, index 0 is A and 1 is B

  logic [WIDTH-1:0] tm_cnt_q [2];
  logic [WIDTH-1:0] tm_cnt_d [2];
  logic [WIDTH-1:0] tm_rel_q [2];
  logic [WIDTH-1:0] tm_rel_d [2];
  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [1:0] loaded_q;
  logic [1:0] loaded_d;
  logic [1:0] tick_en;
  logic [1:0] wrap;
  logic [3:0] div_q;
  logic [3:0] div_d;

  always_comb
  begin
    div_d = div_q;
    if (tick_fall)
      div_d = (div_q == DIV_LAST) ? 4'h0 : div_q + 4'h1;
    if (load_cmd[1] || halt_cmd[1])
      div_d = 4'h0;
    tick_en[0] = tick_fall;
    tick_en[1] = tick_fall && div_q == DIV_LAST;
    for (int i = 0; i < 2; i++)
    begin
      tm_cnt_d[i] = tm_cnt_q[i];
      tm_rel_d[i] = tm_rel_q[i];
      run_d[i] = run_q[i];
      loaded_d[i] = loaded_q[i];
      wrap[i] = 1'b0;
      if (start_cmd[i])
        run_d[i] = 1'b1;
      if (halt_cmd[i] || con_q)
        run_d[i] = 1'b0;
      if (run_q[i] && !con_q && tick_en[i])
      begin
        if (tm_cnt_q[i] == MAXV)
        begin
          wrap[i] = 1'b1;
          tm_cnt_d[i] = (ext_q && loaded_q[i]) ? tm_rel_q[i] : '0;
        end
        else
          tm_cnt_d[i] = tm_cnt_q[i] + 1'b1;
      end
      if (load_cmd[i])
      begin
        tm_cnt_d[i] = reg_wdata[WIDTH-1:0];
        loaded_d[i] = 1'b1;
      end
      if (reload_write_cmd[i])
        tm_rel_d[i] = reg_wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 2; i++)
      begin
        tm_cnt_q[i] <= '0;
        tm_rel_q[i] <= `PTWU_TIMER_RELOAD_RST;
      end
      run_q <= 2'h0;
      loaded_q <= 2'h0;
      div_q <= 4'h0;
    end
    else
    begin
      tm_cnt_q <= tm_cnt_d;
      tm_rel_q <= tm_rel_d;
      run_q <= run_d;
      loaded_q <= loaded_d;
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus timeout monitor

  ptwu_mon_state_type mon_q;
  ptwu_mon_state_type mon_d;
  logic edge_q;
  logic edge_d;
  logic io_q;
  logic io_d;
  logic abort_q;
  logic abort_d;
  logic [15:0] ft_set;

  always_comb
  begin
    mon_d = mon_q;
    edge_d = edge_q;
    io_d = io_q;
    abort_d = 1'b0;
    ft_set = 16'h0000;
    unique case (mon_q)
      PTWU_MON_IDLE:
        if (strobe_fall)
        begin
          mon_d = PTWU_MON_ARMED;
          edge_d = 1'b0;
          io_d = transfer_is_io;
        end
      PTWU_MON_ARMED:
        if (!transfer_ready_n)
          mon_d = PTWU_MON_IDLE;
        else if (tick_fall)
        begin
          if (edge_q)
          begin
            mon_d = PTWU_MON_ABORT;
            abort_d = 1'b1;
            if (io_q)
              ft_set[`PTWU_FAULT_IO_BIT] = 1'b1;
            else
              ft_set[`PTWU_FAULT_MEM_BIT] = 1'b1;
          end
          else
            edge_d = 1'b1;
        end
      PTWU_MON_ABORT:
        if (data_strobe_n)
          mon_d = PTWU_MON_IDLE;
      default:
        mon_d = PTWU_MON_IDLE;
    endcase
    if (!timeout_disable_n)
    begin
      mon_d = PTWU_MON_IDLE;
      edge_d = 1'b0;
      abort_d = 1'b0;
      ft_set = 16'h0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mon_q <= PTWU_MON_IDLE;
      edge_q <= 1'b0;
      io_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      mon_q <= mon_d;
      edge_q <= edge_d;
      io_q <= io_d;
      abort_q <= abort_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags, mask and pending requests

  logic [15:0] ft_q;
  logic [15:0] ft_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] pend_q;
  logic [15:0] pend_d;
  logic [15:0] pend_set;
  logic [15:0] visible;
  logic vis_q;
  logic vis_d;

  always_comb
  begin
    ft_d = (wr_fault ? ft_q & ~reg_wdata : ft_q) | ft_set;
    mask_d = wr_mask ? reg_wdata : mask_q;
    visible = ext_q ? ft_q & mask_q : ft_q;
    vis_d = |visible;
    pend_set = 16'h0000;
    pend_set[`PTWU_IRQ_FAULT_BIT] = vis_d && !vis_q;
    pend_set[`PTWU_IRQ_TA_BIT] = wrap[0];
    pend_set[`PTWU_IRQ_TB_BIT] = wrap[1];
    pend_d = (wr_pend ? pend_q & ~reg_wdata : pend_q) | pend_set;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ft_q <= 16'h0000;
      mask_q <= `PTWU_FAULT_MASK_RST;
      pend_q <= 16'h0000;
      vis_q <= 1'b0;
    end
    else
    begin
      ft_q <= ft_d;
      mask_q <= mask_d;
      pend_q <= pend_d;
      vis_q <= vis_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_read)
    begin
      unique case (reg_addr)
        `PTWU_CTRL_OFF: rdata_d = {14'h0, con_q, ext_q};
        `PTWU_WD_RELOAD_OFF: rdata_d = wd_rel_q;
        `PTWU_WD_COUNT_OFF: rdata_d = wd_cnt_q;
        `PTWU_TA_COUNT_OFF: rdata_d = tm_cnt_q[0];
        `PTWU_TA_RELOAD_OFF: rdata_d = tm_rel_q[0];
        `PTWU_TB_COUNT_OFF: rdata_d = tm_cnt_q[1];
        `PTWU_TB_RELOAD_OFF: rdata_d = tm_rel_q[1];
        `PTWU_TIMER_CMD_OFF: rdata_d = {12'h000, loaded_q, run_q};
        `PTWU_FAULT_OFF: rdata_d = ft_q;
        `PTWU_FAULT_MASK_OFF: rdata_d = mask_q;
        `PTWU_PENDING_OFF: rdata_d = pend_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = rdata_q;
  assign watchdog_expired_n = wd_exp_n_q;
  assign strobe_suppress = mon_q == PTWU_MON_ABORT;
  assign bus_cycle_abort = abort_q;
  assign instr_abort = abort_q;
  assign fault_flags = ft_q;
  assign pending_irq = pend_q;
  assign extended_mode = ext_q;
  assign console_mode = con_q;

endmodule

/* design/ptwu_map.svh */
`ifndef PTWU_MAP_SVH
`define PTWU_MAP_SVH

// Register offsets
`define PTWU_CTRL_OFF 8'h00
`define PTWU_WD_RELOAD_OFF 8'h04
`define PTWU_WD_COUNT_OFF 8'h08
`define PTWU_TA_COUNT_OFF 8'h0c
`define PTWU_TA_RELOAD_OFF 8'h10
`define PTWU_TB_COUNT_OFF 8'h14
`define PTWU_TB_RELOAD_OFF 8'h18
`define PTWU_TIMER_CMD_OFF 8'h1c
`define PTWU_FAULT_OFF 8'h20
`define PTWU_FAULT_MASK_OFF 8'h24
`define PTWU_PENDING_OFF 8'h28

// Field positions
`define PTWU_CTRL_EXT_BIT 0
`define PTWU_CTRL_CONSOLE_BIT 1
`define PTWU_CMD_A_START_BIT 0
`define PTWU_CMD_A_HALT_BIT 1
`define PTWU_CMD_B_START_BIT 2
`define PTWU_CMD_B_HALT_BIT 3
`define PTWU_FAULT_MEM_BIT 8
`define PTWU_FAULT_IO_BIT 5
`define PTWU_IRQ_FAULT_BIT 1
`define PTWU_IRQ_TA_BIT 7
`define PTWU_IRQ_TB_BIT 9

// Reset values
`define PTWU_WD_RELOAD_RST 16'h0000
`define PTWU_TIMER_RELOAD_RST 16'h0000
`define PTWU_FAULT_MASK_RST 16'hffff

// Timing
`define PTWU_TICK_PERIOD_NS 10000
`define PTWU_TB_DIVIDE 10
`define PTWU_BUS_TIMEOUT_EDGES 2

`endif

/* design/ptwu_pkg.sv */
package ptwu_pkg;

  typedef enum logic [2:0] {
    PTWU_MON_IDLE = 3'b001,
    PTWU_MON_ARMED = 3'b010,
    PTWU_MON_ABORT = 3'b100
  } ptwu_mon_state_type;

  typedef logic [15:0] ptwu_word_type;

endpackage

/* tb/ptwu_timer_watchdog_asserts.sv */
`timescale 1ns/10ps
module ptwu_chk #(
  parameter int WIDTH = 16,
  parameter int TB_DIVIDE = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire ptwu_pkg::ptwu_word_type reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire ptwu_pkg::ptwu_word_type reg_rdata,
  // Tick and bus
  input wire logic timer_tick_clock,
  input wire logic data_strobe_n,
  input wire logic transfer_ready_n,
  input wire logic transfer_is_io,
  input wire logic timeout_disable_n,
  // Outputs
  input wire logic strobe_suppress,
  input wire logic bus_cycle_abort,
  input wire logic instr_abort,
  input wire logic watchdog_expired_n,
  input wire ptwu_pkg::ptwu_word_type fault_flags,
  input wire ptwu_pkg::ptwu_word_type pending_irq,
  input wire logic extended_mode,
  input wire logic console_mode
);
  import ptwu_pkg::*;
  logic tick_d;
  logic tick_q;
  logic tick_fall;
  ////////////////////////////////////////////////////////////////
  // Tick falling edge seen
  always_comb tick_d = reset ? 1'b0 : timer_tick_clock;
  always_ff @(posedge clk) tick_q <= tick_d;
  assign tick_fall = tick_q & ~timer_tick_clock;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_reload_cmd;
    reg_write && reg_addr == 8'h08;
  endsequence
  sequence s_tick_fall;
    tick_fall;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_expiry_hold: assert property (
    !watchdog_expired_n && !(reg_write && reg_addr == 8'h08) |=> !watchdog_expired_n)
    else $error("expiry released early");
  chk_expiry_release: assert property (s_reload_cmd |=> watchdog_expired_n)
    else $error("expiry not released");
  chk_expiry_cause: assert property ($fell(watchdog_expired_n) |-> $past(tick_fall))
    else $error("expiry without tick");
  chk_abort_pair: assert property (bus_cycle_abort |-> instr_abort && strobe_suppress)
    else $error("abort outputs differ");
  chk_abort_pulse: assert property (bus_cycle_abort |=> !bus_cycle_abort)
    else $error("abort too long");
  chk_abort_cause: assert property (bus_cycle_abort |-> $past(tick_fall))
    else $error("abort not after tick");
  chk_fault_bit: assert property ($rose(bus_cycle_abort) |-> fault_flags[8] || fault_flags[5])
    else $error("timeout flag missing");
  chk_fault_irq: assert property (
    $rose(fault_flags != 16'h0000) && !extended_mode |=> pending_irq[1])
    else $error("fault level missing");
  chk_disable_idle: assert property (
    !timeout_disable_n [*2] |-> !strobe_suppress && !bus_cycle_abort)
    else $error("monitor active when disabled");
  chk_console_freeze: assert property (
    console_mode [*3] ##0 !pending_irq[7] |=> !pending_irq[7])
    else $error("timer ran in console");
  cov_abort: cover property (s_tick_fall ##1 bus_cycle_abort);
endmodule

bind ptwu_timer_watchdog ptwu_chk #(.WIDTH(WIDTH), .TB_DIVIDE(TB_DIVIDE)) chk_u (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .timer_tick_clock(timer_tick_clock), .data_strobe_n(data_strobe_n),
  .transfer_ready_n(transfer_ready_n), .transfer_is_io(transfer_is_io),
  .timeout_disable_n(timeout_disable_n), .strobe_suppress(strobe_suppress),
  .bus_cycle_abort(bus_cycle_abort), .instr_abort(instr_abort),
  .watchdog_expired_n(watchdog_expired_n), .fault_flags(fault_flags),
  .pending_irq(pending_irq), .extended_mode(extended_mode), .console_mode(console_mode));

/* tb/ptwu_bus_model.sv */
`timescale 1ns/10ps
module ptwu_bus_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench request
  input wire logic go,
  input wire logic io,
  input wire logic [7:0] lat,
  // Device side
  input wire logic strobe_suppress,
  output logic data_strobe_n,
  output logic transfer_ready_n,
  output logic transfer_is_io
);
  logic busy_q, busy_d, dsn_d, rdy_d, io_d;
  logic [7:0] wait_q, wait_d;
  ////////////////////////////////////////////////////////////////
  // One transfer, answered after lat cycles or cut by suppression
  always_comb
  begin
    busy_d = busy_q;
    wait_d = wait_q;
    dsn_d = data_strobe_n;
    rdy_d = transfer_ready_n;
    io_d = transfer_is_io;
    if (go && !busy_q)
    begin
      busy_d = 1'b1;
      dsn_d = 1'b0;
      wait_d = lat;
      io_d = io;
    end
    else if (busy_q && (strobe_suppress || !transfer_ready_n))
    begin
      busy_d = 1'b0;
      dsn_d = 1'b1;
      rdy_d = 1'b1;
    end
    else if (busy_q && wait_q == 8'h00)
      rdy_d = 1'b0;
    else if (busy_q)
      wait_d = wait_q - 8'h01;
  end
  always_ff @(posedge clk)
  begin
    busy_q <= reset ? 1'b0 : busy_d;
    wait_q <= reset ? 8'h00 : wait_d;
    data_strobe_n <= reset ? 1'b1 : dsn_d;
    transfer_ready_n <= reset ? 1'b1 : rdy_d;
    transfer_is_io <= reset ? 1'b0 : io_d;
  end
endmodule

/* tb/ptwu_timer_watchdog_tb.sv */
`timescale 1ns/10ps
module ptwu_timer_watchdog_tb;
  import ptwu_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  ptwu_word_type reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic tick = 1'b0;
  logic tdis_n = 1'b1;
  logic go = 1'b0;
  logic io = 1'b0;
  logic [7:0] lat = 8'h00;
  logic strobe_n, rdy_n, is_io, supp, wd_n;
  ptwu_word_type rdata, flags, pend;
  int miscompares = 0;
  int checks_done = 0;
  ptwu_word_type ef [5] = '{16'h0100, 16'h0020, 16'h0000, 16'h0000, 16'h0100};
  ptwu_word_type ep [5] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
  ptwu_word_type msk [5] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0000};
  logic [4:0] ctl = 5'h10;
  logic [4:0] dis = 5'h17;
  logic [4:0] ios = 5'h02;
  logic [7:0] lats [5] = '{8'hc8, 8'hc8, 8'h01, 8'hc8, 8'hc8};
  always #2 clk = ~clk;
  ptwu_timer_watchdog dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
    .timer_tick_clock(tick), .data_strobe_n(strobe_n), .transfer_ready_n(rdy_n),
    .transfer_is_io(is_io), .timeout_disable_n(tdis_n), .strobe_suppress(supp),
    .bus_cycle_abort(), .instr_abort(), .watchdog_expired_n(wd_n), .fault_flags(flags),
    .pending_irq(pend), .extended_mode(), .console_mode());
  ptwu_bus_model bus_u (.clk(clk), .reset(reset), .go(go), .io(io), .lat(lat),
    .strobe_suppress(supp), .data_strobe_n(strobe_n), .transfer_ready_n(rdy_n),
    .transfer_is_io(is_io));
  ////////////////////////////////////////////////////////////////
  // Access and check tasks
  task automatic wr(input logic [7:0] a, input ptwu_word_type d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic ck(input ptwu_word_type s, input ptwu_word_type e);
    checks_done++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input ptwu_word_type e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    ck(rdata, e);
  endtask
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge clk);
      tick <= 1'b1;
      repeat (2) @(posedge clk);
      tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    #1;
  endtask
  task automatic give_verdict;
    $display("Checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rc(8'h04, 16'h0000);
    rc(8'h10, 16'h0000);
    rc(8'h18, 16'h0000);
    rc(8'h24, 16'hffff);
    rc(8'hfc, 16'h0000);
    tk(1);
    rc(8'h08, 16'h0001);
    $display("Test reset done");
    wr(8'h04, 16'hfffe);
    wr(8'h08, 16'h0000);
    rc(8'h08, 16'hfffe);
    tk(1);
    ck(wd_n, 16'h0001);
    tk(1);
    ck(wd_n, 16'h0000);
    tk(1);
    rc(8'h08, 16'h0001);
    ck(wd_n, 16'h0000);
    wr(8'h08, 16'h0000);
    ck(wd_n, 16'h0001);
    wr(8'h04, 16'h0000);
    wr(8'h08, 16'h0000);
    rc(8'h08, 16'h0000);
    $display("Test watchdog done");
    wr(8'h0c, 16'hfffe);
    wr(8'h1c, 16'h0001);
    tk(2);
    wr(8'h1c, 16'h0002);
    ck(pend[7], 16'h0001);
    rc(8'h1c, 16'h0004);
    tk(1);
    rc(8'h0c, 16'h0000);
    wr(8'h28, 16'hffff);
    wr(8'h00, 16'h0002);
    wr(8'h1c, 16'h0001);
    tk(1);
    rc(8'h0c, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h1c, 16'h0004);
    tk(4);
    wr(8'h1c, 16'h0008);
    wr(8'h14, 16'hffff);
    wr(8'h1c, 16'h0004);
    tk(9);
    ck(pend[9], 16'h0000);
    tk(1);
    ck(pend[9], 16'h0001);
    wr(8'h1c, 16'h0008);
    wr(8'h00, 16'h0001);
    wr(8'h10, 16'h1234);
    rc(8'h10, 16'h1234);
    wr(8'h0c, 16'hffff);
    wr(8'h1c, 16'h0001);
    tk(1);
    wr(8'h1c, 16'h0002);
    rc(8'h0c, 16'h1234);
    $display("Test timers done");
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h00, {15'h0000, ctl[i]});
      wr(8'h24, msk[i]);
      wr(8'h20, 16'hffff);
      wr(8'h28, 16'hffff);
      @(posedge clk);
      tdis_n <= dis[i];
      io <= ios[i];
      lat <= lats[i];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      tk(2);
      ck(flags, ef[i]);
      ck(pend[1], ep[i]);
      repeat (260) @(posedge clk);
      tdis_n <= 1'b1;
    end
    $display("Test bus monitor done");
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
